// >>> rtl/cpcc_top.v
// Channel pair combine control: register slice and pair steering
//
// Contract
// RQ1: Bit 20 enables deadtime on pair 4/5
// RQ2: Protected fields written only with protect disabled
// RQ3: Bit 19 arms dual-edge capture, pair 4
// RQ4: Arm effective only with feature and mode
// RQ5: One-shot: arm clears after second capture
// RQ6: Bit 18 selects dual-edge capture mode
// RQ7: Mode enable effective only with feature enable
// RQ8: Bit 17 makes channel 5 inverse of 4 (code inverts only while bit 16 is set; otherwise ch5_out follows ch5_pwm)
// RQ9: Bit 16 combines channels 4 and 5
// RQ10: Bit 15 reserved, reads zero
// RQ11: Bit 14 fault enable for pair 2/3
// RQ12: Fault enable 0 disables, 1 enables
// RQ13: All slice fields reset to zero
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "cpcc_defines.vh"
module cpcc_top (
  input  wire        ref_clk,        // 125 MHz clock
  input  wire        rst,            // Async reset, high
  input  wire [3:0]  addr,           // Register address
  input  wire [31:0] wdata,          // Write data
  input  wire        wr,             // Write strobe
  input  wire        rd,             // Read strobe
  output reg  [31:0] rdata,          // Read data, cycle after rd
  input  wire        ch4_in_evt,     // Channel 4 input edge event
  input  wire        ch5_in_evt,     // Channel 5 input edge event
  input  wire [15:0] counter,        // Shared timer counter
  input  wire        ch4_pwm,        // Channel 4 generated output
  input  wire        ch5_pwm,        // Channel 5 generated output
  output reg         ch5_out,        // Channel 5 steered output
  output reg         pair2_deadtime_active,  // Deadtime applied
  output reg         pair2_combined,         // Pair combined
  output reg         pair2_dual_capture,     // Dual capture mode live
  output reg         pair1_fault_active,     // Fault control on
  output reg  [15:0] cap_first,      // Counter at channel 4 event
  output reg  [15:0] cap_second,     // Counter at channel 5 event
  output reg         cap_done        // Pulse: pair capture complete
);
  wire wr_comb = wr && (addr == `CPCC_COMBINE_ADDR);
  wire wr_mode = wr && (addr == `CPCC_MODE_ADDR);
  reg  [2:0] mode_r;
  wire extended_feature_enable = mode_r[`CPCC_MODE_BIT_FEN];
  wire write_protect_disable   = mode_r[`CPCC_MODE_BIT_WRITE_PROTECT_DISABLE];
  wire one_shot                = mode_r[`CPCC_MODE_BIT_ONESHOT];

  wire pair2_deadtime_enable;
  wire pair2_dual_capture_mode_enable;
  wire pair2_complement_select;
  wire pair2_combine_select;
  wire pair1_fault_control_enable;
  wire pair2_dual_capture_arm;

  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      mode_r <= `CPCC_RST_MODE;
    else if (wr_mode)
      mode_r <= wdata[2:0];
  end

  // Protected bits, one instance each
  cpcc_prot_bit u_dten (  // RQ1 RQ2 RQ13
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_comb),
    .wp_dis  (write_protect_disable),
    .din     (wdata[`CPCC_BIT_DTEN]),
    .q_r     (pair2_deadtime_enable)
  );
  cpcc_prot_bit u_dcen (  // RQ6 RQ2 RQ13
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_comb),
    .wp_dis  (write_protect_disable),
    .din     (wdata[`CPCC_BIT_DCEN]),
    .q_r     (pair2_dual_capture_mode_enable)
  );
  cpcc_prot_bit u_comp (  // RQ8 RQ2 RQ13
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_comb),
    .wp_dis  (write_protect_disable),
    .din     (wdata[`CPCC_BIT_COMP]),
    .q_r     (pair2_complement_select)
  );
  cpcc_prot_bit u_comb (  // RQ9 RQ2 RQ13
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_comb),
    .wp_dis  (write_protect_disable),
    .din     (wdata[`CPCC_BIT_COMB]),
    .q_r     (pair2_combine_select)
  );
  cpcc_prot_bit u_flt (  // RQ11 RQ2 RQ13
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_comb),
    .wp_dis  (write_protect_disable),
    .din     (wdata[`CPCC_BIT_FLTEN]),
    .q_r     (pair1_fault_control_enable)
  );

  // Capture sequencer, one-hot
  localparam ST_IDLE  = 3'b001;
  localparam ST_WAIT1 = 3'b010;
  localparam ST_WAIT2 = 3'b100;
  reg  [2:0] st_r;
  reg  [2:0] st_nxt;

  wire dc_live  = extended_feature_enable &&
                  pair2_dual_capture_mode_enable;  // RQ7
  wire arm_live = dc_live && pair2_dual_capture_arm;  // RQ4
  wire second_hit = (st_r == ST_WAIT2) && ch5_in_evt && arm_live;
  wire hw_clr   = second_hit && one_shot;  // RQ5

  // Arm is not protected; only hardware or software change it
  cpcc_arm_bit u_arm (  // RQ3 RQ13
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_comb),
    .din     (wdata[`CPCC_BIT_ARM]),
    .hw_clr  (hw_clr),
    .q_r     (pair2_dual_capture_arm)
  );

  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:  if (arm_live) st_nxt = ST_WAIT1;
      ST_WAIT1: begin
        if (!arm_live)
          st_nxt = ST_IDLE;
        else if (ch4_in_evt)
          st_nxt = ST_WAIT2;
      end
      ST_WAIT2: begin
        if (!arm_live)
          st_nxt = ST_IDLE;
        else if (ch5_in_evt)
          st_nxt = one_shot ? ST_IDLE : ST_WAIT1;
      end
      default:  st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r       <= ST_IDLE;
      cap_first  <= 16'h0000;
      cap_second <= 16'h0000;
      cap_done   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cap_done <= second_hit;  // RQ3
      if ((st_r == ST_WAIT1) && ch4_in_evt && arm_live)
        cap_first <= counter;  // RQ3
      if (second_hit)
        cap_second <= counter;
    end
  end

  // Steered outputs, all registered
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ch5_out               <= 1'b0;
      pair2_deadtime_active <= 1'b0;
      pair2_combined        <= 1'b0;
      pair2_dual_capture    <= 1'b0;
      pair1_fault_active    <= 1'b0;
    end else begin
      if (pair2_combine_select)  // RQ9
        ch5_out <= pair2_complement_select ? ~ch4_pwm : ch4_pwm;  // RQ8
      else
        ch5_out <= ch5_pwm;
      pair2_deadtime_active <= pair2_deadtime_enable;  // RQ1
      pair2_combined        <= pair2_combine_select;
      pair2_dual_capture    <= dc_live;  // RQ6
      pair1_fault_active    <= pair1_fault_control_enable;  // RQ12
    end
  end

  // Read mux; unmapped addresses read zero
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h00000000;
    case (addr)
      `CPCC_COMBINE_ADDR: begin
        rd_val[`CPCC_BIT_DTEN]  = pair2_deadtime_enable;
        rd_val[`CPCC_BIT_ARM]   = pair2_dual_capture_arm;
        rd_val[`CPCC_BIT_DCEN]  = pair2_dual_capture_mode_enable;
        rd_val[`CPCC_BIT_COMP]  = pair2_complement_select;
        rd_val[`CPCC_BIT_COMB]  = pair2_combine_select;
        rd_val[`CPCC_BIT_RSVD]  = 1'b0;  // RQ10
        rd_val[`CPCC_BIT_FLTEN] = pair1_fault_control_enable;
      end
      `CPCC_MODE_ADDR:   rd_val[2:0] = mode_r;
      `CPCC_STATUS_ADDR: rd_val[2:0] = st_r;
      default:           rd_val = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      rdata <= 32'h00000000;
    else if (rd)
      rdata <= rd_val;
    else
      rdata <= 32'h00000000;
  end
endmodule

// >>> rtl/cpcc_defines.vh
// Constants for the channel pair combine control slice
`ifndef CPCC_DEFINES_VH
`define CPCC_DEFINES_VH
`define CPCC_ADDR_W          4
`define CPCC_COMBINE_ADDR    4'h0
`define CPCC_MODE_ADDR       4'h1
`define CPCC_STATUS_ADDR     4'h2
`define CPCC_BIT_DTEN        20
`define CPCC_BIT_ARM         19
`define CPCC_BIT_DCEN        18
`define CPCC_BIT_COMP        17
`define CPCC_BIT_COMB        16
`define CPCC_BIT_RSVD        15
`define CPCC_BIT_FLTEN       14
`define CPCC_MODE_BIT_FEN    0
`define CPCC_MODE_BIT_WRITE_PROTECT_DISABLE  1
`define CPCC_MODE_BIT_ONESHOT 2
`define CPCC_RST_BIT         1'b0
`define CPCC_RST_MODE        3'h0
`endif

// >>> rtl/cpcc_prot_bit.v
// One write-protected control bit
`timescale 1ns/100ps
`include "cpcc_defines.vh"
module cpcc_prot_bit (
  input  wire ref_clk,  // Clock
  input  wire rst,      // Async reset, high
  input  wire wr_en,    // Write of owning register
  input  wire wp_dis,   // Write protect disable
  input  wire din,      // Written value
  output reg  q_r       // Stored bit
);
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      q_r <= `CPCC_RST_BIT;
    else if (wr_en && wp_dis)
      q_r <= din;
  end
endmodule

// >>> rtl/cpcc_arm_bit.v
// Dual capture arm bit with hardware self clear
`timescale 1ns/100ps
`include "cpcc_defines.vh"
module cpcc_arm_bit (
  input  wire ref_clk,  // Clock
  input  wire rst,      // Async reset, high
  input  wire wr_en,    // Software write
  input  wire din,      // Written value
  input  wire hw_clr,   // One-shot completion clear
  output reg  q_r       // Arm bit
);
  // Hardware clear wins: capture finished, arm must drop
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      q_r <= `CPCC_RST_BIT;
    else if (hw_clr)
      q_r <= 1'b0;
    else if (wr_en)
      q_r <= din;
  end
endmodule

// >>> bench/cpcc_properties.sv
// Port-level properties of the channel pair combine control slice
`timescale 1ns/100ps
`include "cpcc_defines.vh"
module cpcc_props (
  input wire        ref_clk,               // Clock
  input wire        rst,                   // Reset
  input wire [3:0]  addr,                  // Address
  input wire [31:0] wdata,                 // Write data
  input wire        wr,                    // Write
  input wire        rd,                    // Read
  input wire [31:0] rdata,                 // Read data
  input wire        ch5_pwm,               // Ch5 level
  input wire        ch5_out,               // Ch5 steered
  input wire        ch5_in_evt,            // Ch5 event
  input wire        pair2_deadtime_active, // Deadtime
  input wire        pair2_combined,        // Combined
  input wire        pair2_dual_capture,    // Dual live
  input wire        pair1_fault_active,    // Fault on
  input wire        cap_done               // Done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Field outputs lag the write by two cycles
  sequence s_cw;
    $past(wr && addr == `CPCC_COMBINE_ADDR, 2);
  endsequence
  property p_rsvd; rdata[15] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_idle; !$past(rd) |-> rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_indep; !pair2_combined |-> ch5_out == $past(ch5_pwm);
  endproperty
  a_indep: assert property (p_indep) else $error("ch5 not own");
  property p_dten; $rose(pair2_deadtime_active) |-> s_cw; endproperty
  a_dten: assert property (p_dten) else $error("deadtime rose");
  property p_comb; $rose(pair2_combined) |-> s_cw; endproperty
  a_comb: assert property (p_comb) else $error("combine rose");
  property p_flt; $rose(pair1_fault_active) |-> s_cw; endproperty
  a_flt: assert property (p_flt) else $error("fault rose");
  property p_dual; $rose(pair2_dual_capture) |-> $past(wr, 2); endproperty
  a_dual: assert property (p_dual) else $error("dual rose");
  property p_done; cap_done |=> !cap_done; endproperty
  a_done: assert property (p_done) else $error("done too long");
  property p_src; cap_done |-> $past(ch5_in_evt) || $past(ch5_in_evt, 2);
  endproperty
  a_src: assert property (p_src) else $error("done no event");
endmodule
bind cpcc_top cpcc_props u_props (.ref_clk, .rst, .addr, .wdata, .wr, .rd,
  .rdata, .ch5_pwm, .ch5_out, .ch5_in_evt, .pair2_deadtime_active,
  .pair2_combined, .pair2_dual_capture, .pair1_fault_active, .cap_done);

// >>> bench/channel_pair_combine_control_tb_top.sv
// Self-checking bench for the channel pair combine control slice
`timescale 1ns/100ps
`include "cpcc_defines.vh"
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin \
  errors++; $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module channel_pair_combine_control_tb_top;
  reg         ref_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [3:0]  addr = 4'h0;
  reg  [31:0] wdata = 32'h0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg         ch4_in_evt = 1'b0;
  reg         ch5_in_evt = 1'b0;
  reg  [15:0] counter = 16'h0;
  reg         ch4_pwm = 1'b0;
  reg         ch5_pwm = 1'b0;
  wire [31:0] rdata;
  wire        ch5_out, pair2_deadtime_active, pair2_combined;
  wire        pair2_dual_capture, pair1_fault_active, cap_done;
  wire [15:0] cap_first, cap_second;
  int         errors = 0;
  int         total_checks = 0;
  int         i;
  reg  [31:0] rv, e;
  // Rows: written word, expected read-back
  reg  [63:0] rows [0:6] = '{64'h00100000_00100000, 64'h00040000_00040000,
    64'h00030000_00030000, 64'h00010000_00010000, 64'h0000c000_00004000,
    64'hffffffff_001f4000, 64'h0};
  cpcc_top DUT (.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .ch4_in_evt, .ch5_in_evt, .counter, .ch4_pwm, .ch5_pwm, .ch5_out,
    .pair2_deadtime_active, .pair2_combined, .pair2_dual_capture,
    .pair1_fault_active, .cap_first, .cap_second, .cap_done);
  task wr_reg(input [3:0] a, input [31:0] d);
    @(posedge ref_clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge ref_clk); wr <= 1'b0;
  endtask
  task rd_reg(input [3:0] a);
    @(posedge ref_clk); addr <= a; rd <= 1'b1;
    @(posedge ref_clk); rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #4 ref_clk = ~ref_clk;
  // Whole run is under a hundred cycles; the time limit is 2500 cycles
  initial begin
    #20000 errors++;
    results;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(`CPCC_COMBINE_ADDR); `CHK("reset", 32'h0, rv)
    $display("reset test done");
    wr_reg(`CPCC_MODE_ADDR, 32'h2);
    ch4_pwm <= 1'b1;
    for (i = 0; i < 7; i++) begin
      e = rows[i][31:0];
      wr_reg(`CPCC_COMBINE_ADDR, rows[i][63:32]);
      rd_reg(`CPCC_COMBINE_ADDR); `CHK("word", e, rv)
      `CHK("dten", e[20], pair2_deadtime_active)
      `CHK("comb", e[16], pair2_combined)
      `CHK("flt", e[14], pair1_fault_active)
      `CHK("ch5", e[16] ? ~e[17] : 1'b0, ch5_out)
    end
    $display("table test done");
    wr_reg(`CPCC_MODE_ADDR, 32'h0);
    wr_reg(`CPCC_COMBINE_ADDR, 32'hffffffff);
    rd_reg(`CPCC_COMBINE_ADDR); `CHK("locked", 32'h80000, rv)
    rd_reg(4'h3); `CHK("unmapped", 32'h0, rv)
    wr_reg(`CPCC_MODE_ADDR, 32'h2);
    wr_reg(`CPCC_COMBINE_ADDR, 32'h40000);
    @(posedge ref_clk); #1 `CHK("nofen", 1'b0, pair2_dual_capture)
    wr_reg(`CPCC_MODE_ADDR, 32'h7);
    wr_reg(`CPCC_COMBINE_ADDR, 32'hc0000);
    #1 `CHK("live", 1'b1, pair2_dual_capture)
    repeat (2) @(posedge ref_clk);
    counter <= 16'h1234;
    ch4_in_evt <= 1'b1;
    @(posedge ref_clk); ch4_in_evt <= 1'b0; counter <= 16'h5678;
    ch5_in_evt <= 1'b1;
    @(posedge ref_clk); ch5_in_evt <= 1'b0;
    #1 i = 0;
    while (cap_done !== 1'b1 && i < 8) begin
      @(posedge ref_clk); #1 i++;
    end
    `CHK("done", 1'b1, cap_done)
    `CHK("first", 16'h1234, cap_first)
    `CHK("second", 16'h5678, cap_second)
    rd_reg(`CPCC_COMBINE_ADDR); `CHK("disarm", 32'h40000, rv)
    $display("capture test done");
    wr_reg(`CPCC_MODE_ADDR, 32'h3);
    wr_reg(`CPCC_COMBINE_ADDR, 32'hc0000);
    repeat (2) @(posedge ref_clk);
    counter <= 16'h0aaa;
    ch4_in_evt <= 1'b1;
    @(posedge ref_clk); ch4_in_evt <= 1'b0; counter <= 16'h0bbb;
    ch5_in_evt <= 1'b1;
    @(posedge ref_clk); ch5_in_evt <= 1'b0;
    #1 `CHK("cdone", 1'b1, cap_done)
    `CHK("cfirst", 16'h0aaa, cap_first)
    `CHK("csecond", 16'h0bbb, cap_second)
    rd_reg(`CPCC_COMBINE_ADDR); `CHK("stay", 32'hc0000, rv)
    $display("continuous test done");
    @(posedge ref_clk); rst <= 1'b1;
    @(posedge ref_clk); rst <= 1'b0;
    rd_reg(`CPCC_COMBINE_ADDR); `CHK("rerst", 32'h0, rv)
    `CHK("rerst_dual", 1'b0, pair2_dual_capture)
    $display("second reset test done");
    results;
  end
endmodule
